// ==== hw/addr_space_pkg.sv ====
// shared constants and types for the address space and stack block
package addr_space_pkg;
  localparam int PROG_AW = 12;
  localparam int PROG_BYTES = 4096;
  localparam logic [11:0] PROG_LAST = 12'hfff;
  localparam logic [11:0] VEC_HI_ADDR = 12'h000;
  localparam logic [11:0] VEC_LO_ADDR = 12'h001;
  localparam logic [15:0] RESET_ENTRY = 16'h0100;
  localparam logic [11:0] OPT_SPARE0 = 12'h03c;
  localparam logic [11:0] OPT_SPARE1 = 12'h03d;
  localparam logic [11:0] OPT_RESET_CFG = 12'h03e;
  localparam logic [11:0] OPT_CLOCK_CFG = 12'h03f;
  localparam logic [7:0] OPT_ERASED = 8'hff;
  localparam int OPT_RESET_EN_BIT = 7;
  localparam logic [1:0] OPT_CLOCK_RC = 2'h3;
  localparam logic [15:0] VEC_ERASED = 16'hffff;
  localparam logic [7:0] GP_TOP = 8'hbf;
  localparam logic [3:0] WORK_PAGE = 4'hc;
  localparam logic [7:0] WORK_TOP = 8'hcf;
  localparam logic [7:0] STACK_PTR_ADDR = 8'hd9;
  localparam int GP_BYTES = 208;
  localparam int SYS_CTRL_BYTES = 11;
  localparam int PERI_CTRL_BYTES = 15;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_CALL = 3'h1,
    CMD_INT = 3'h2,
    CMD_SUB_RETURN = 3'h3,
    CMD_INT_RETURN = 3'h4
  } stack_cmd_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH_LO = 3'h1,
    ST_PUSH_HI = 3'h3,
    ST_PUSH_FL = 3'h2,
    ST_DONE = 3'h6,
    ST_POP_FL = 3'h7,
    ST_POP_HI = 3'h5,
    ST_POP_LO = 3'h4
  } stack_state_e;
endpackage

// ==== hw/stack_link_if.sv ====
// link between the stack sequencer and the register file owner
`timescale 1ns/1ps
interface stack_link_if;
  addr_space_pkg::stack_cmd_e cmd;
  logic [15:0] program_counter_in;
  logic [7:0] flags_in;
  logic busy;
  logic done;
  logic [15:0] program_counter_out;
  logic [7:0] flags_out;
  logic push_en;
  logic [7:0] push_data;
  logic pop_en;
  logic [7:0] pop_data;
  modport seq (input cmd, program_counter_in, flags_in, pop_data,
    output busy, done, program_counter_out, flags_out, push_en, push_data, pop_en);
  modport mem (output cmd, program_counter_in, flags_in, pop_data,
    input busy, done, program_counter_out, flags_out, push_en, push_data, pop_en);
endinterface

// ==== hw/stack_seq.sv ====
// byte sequencer for call, interrupt and return stack traffic
`timescale 1ns/1ps
module stack_seq (
  input wire logic clk,
  input wire logic rst_n,
  stack_link_if.seq lnk
);
  addr_space_pkg::stack_state_e state, next_state;
  logic is_int, next_is_int;
  logic [15:0] pc_hold, next_pc_hold;
  logic [7:0] fl_hold, next_fl_hold;

  always_comb begin
    next_state = state;
    next_is_int = is_int;
    next_pc_hold = pc_hold;
    next_fl_hold = fl_hold;
    lnk.push_en = 1'b0;
    lnk.pop_en = 1'b0;
    lnk.push_data = 8'h00;
    case (state)
      addr_space_pkg::ST_IDLE: begin
        case (lnk.cmd)
          addr_space_pkg::CMD_CALL, addr_space_pkg::CMD_INT: begin
            next_state = addr_space_pkg::ST_PUSH_LO;
            next_is_int = (lnk.cmd == addr_space_pkg::CMD_INT);
            next_pc_hold = lnk.program_counter_in;
            next_fl_hold = lnk.flags_in;
          end
          addr_space_pkg::CMD_SUB_RETURN: begin
            next_state = addr_space_pkg::ST_POP_HI;
            next_is_int = 1'b0;
          end
          addr_space_pkg::CMD_INT_RETURN: begin
            next_state = addr_space_pkg::ST_POP_FL;
            next_is_int = 1'b1;
          end
          default: next_state = addr_space_pkg::ST_IDLE;
        endcase
      end
      addr_space_pkg::ST_PUSH_LO: begin
        lnk.push_en = 1'b1;
        lnk.push_data = pc_hold[7:0];
        next_state = addr_space_pkg::ST_PUSH_HI;
      end
      addr_space_pkg::ST_PUSH_HI: begin
        lnk.push_en = 1'b1;
        lnk.push_data = pc_hold[15:8];
        next_state = is_int ? addr_space_pkg::ST_PUSH_FL : addr_space_pkg::ST_DONE;
      end
      addr_space_pkg::ST_PUSH_FL: begin
        lnk.push_en = 1'b1;
        lnk.push_data = fl_hold;
        next_state = addr_space_pkg::ST_DONE;
      end
      addr_space_pkg::ST_POP_FL: begin
        lnk.pop_en = 1'b1;
        next_fl_hold = lnk.pop_data;
        next_state = addr_space_pkg::ST_POP_HI;
      end
      addr_space_pkg::ST_POP_HI: begin
        lnk.pop_en = 1'b1;
        next_pc_hold = {lnk.pop_data, pc_hold[7:0]};
        next_state = addr_space_pkg::ST_POP_LO;
      end
      addr_space_pkg::ST_POP_LO: begin
        lnk.pop_en = 1'b1;
        next_pc_hold = {pc_hold[15:8], lnk.pop_data};
        next_state = addr_space_pkg::ST_DONE;
      end
      addr_space_pkg::ST_DONE: next_state = addr_space_pkg::ST_IDLE;
      default: next_state = addr_space_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= addr_space_pkg::ST_IDLE;
      is_int <= 1'b0;
      pc_hold <= 16'h0000;
      fl_hold <= 8'h00;
    end else begin
      state <= next_state;
      is_int <= next_is_int;
      pc_hold <= next_pc_hold;
      fl_hold <= next_fl_hold;
    end
  end

  assign lnk.busy = (state != addr_space_pkg::ST_IDLE);
  assign lnk.done = (state == addr_space_pkg::ST_DONE);
  assign lnk.program_counter_out = pc_hold;
  assign lnk.flags_out = fl_hold;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_call_start;
    state == addr_space_pkg::ST_IDLE && lnk.cmd == addr_space_pkg::CMD_CALL;
  endsequence
  sequence s_int_start;
    state == addr_space_pkg::ST_IDLE && lnk.cmd == addr_space_pkg::CMD_INT;
  endsequence
  sequence s_interrupt_return_start;
    state == addr_space_pkg::ST_IDLE && lnk.cmd == addr_space_pkg::CMD_INT_RETURN;
  endsequence
  sequence s_two_push;
    lnk.push_en[*2] ##1 lnk.done;
  endsequence
  sequence s_three_push;
    lnk.push_en[*3] ##1 lnk.done;
  endsequence
  chk_call_push_pc: assert property (s_call_start |=> s_two_push)
    else $error("call did not push two bytes then finish");
  chk_int_push_all: assert property (s_int_start |=> s_three_push)
    else $error("interrupt did not push three bytes then finish");
  chk_interrupt_return_pop_all: assert property (s_interrupt_return_start |=> lnk.pop_en[*3] ##1 lnk.done)
    else $error("interrupt return did not pop three bytes");
  chk_push_byte_order: assert property (s_call_start |=>
    lnk.push_data == $past(lnk.program_counter_in[7:0]) ##1
    lnk.push_data == $past(lnk.program_counter_in[15:8], 2))
    else $error("program counter bytes pushed in wrong order");
endmodule

// ==== hw/addr_space_stack.sv ====
// program memory, register file and stack pointer of the small core
`timescale 1ns/1ps
// Notes on behaviour
// - program memory uses a 12-bit address
// - register file has its own 8-bit bus
// - 4 Kbytes of program memory, 000 to FFF
// - bytes 0000-0001 hold the interrupt vector
// - execution starts at 0100 after reset
// - option bytes 3C-3F, only 3E, 3F used
// - erased FF: low-voltage reset on, internal RC
// - top 64 bytes: working and control registers
// - bytes 00-BF are general purpose
// - single page, no page selection
// - 208 general bytes, 26 control bytes
// - C0-CF working area, 4-bit register number
// - pair: even byte high, odd byte low
// - call pushes, return pops the program counter
// - interrupt pushes counter and flags, return pops
// - decrement before push, increment after pop
// - 8-bit stack pointer at D9, stack in file
// - stack pointer has no reset value
// - stack pointer 00 wraps to FF on push
module addr_space_stack #(
  parameter int PROG_DEPTH = addr_space_pkg::PROG_BYTES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic img_wr,
  input wire logic [11:0] img_addr,
  input wire logic [7:0] img_wdata,
  input wire logic prog_rd,
  input wire logic [11:0] prog_addr,
  output logic [7:0] prog_rdata,
  output logic [15:0] reset_entry,
  output logic [15:0] irq_vector,
  output logic low_voltage_reset_en,
  output logic internal_rc_sel,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_work,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_busy,
  output logic ctrl_sel,
  input wire logic [7:0] ctrl_rdata,
  input wire logic pair_rd,
  input wire logic [7:0] pair_addr,
  output logic [15:0] pair_rdata,
  input wire addr_space_pkg::stack_cmd_e stack_cmd,
  input wire logic [15:0] program_counter_in,
  input wire logic [7:0] flags_in,
  output logic stack_busy,
  output logic stack_done,
  output logic [15:0] program_counter_out,
  output logic [7:0] flags_out,
  output logic [7:0] stack_pointer
);
  logic [7:0] prog_mem [PROG_DEPTH];
  logic [7:0] rf [256];
  logic [7:0] next_prog_rdata;
  logic [7:0] opt_reset_cfg, next_opt_reset_cfg;
  logic [7:0] opt_clock_cfg, next_opt_clock_cfg;
  logic [15:0] vec, next_vec;
  logic [7:0] next_stack_pointer;
  logic [7:0] eff_addr;
  logic acc_ok;
  logic rf_we;
  logic [7:0] rf_waddr, rf_wdata;
  logic [7:0] next_reg_rdata;
  logic [15:0] next_pair_rdata;
  logic [7:0] pair_even;
  logic [7:0] push_slot;

  stack_link_if lnk ();

  stack_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .lnk(lnk.seq)
  );

  assign lnk.cmd = stack_cmd;
  assign lnk.program_counter_in = program_counter_in;
  assign lnk.flags_in = flags_in;
  assign lnk.pop_data = rf[stack_pointer];
  assign stack_busy = lnk.busy;
  assign stack_done = lnk.done;
  assign program_counter_out = lnk.program_counter_out;
  assign flags_out = lnk.flags_out;

  // program memory: image load port and fetch port share the array
  always_ff @(posedge clk) begin
    if (img_wr) begin
      prog_mem[img_addr] <= img_wdata;
    end
  end

  always_comb begin
    next_prog_rdata = prog_rdata;
    next_opt_reset_cfg = opt_reset_cfg;
    next_opt_clock_cfg = opt_clock_cfg;
    next_vec = vec;
    if (prog_rd) begin
      next_prog_rdata = prog_mem[prog_addr];
    end
    if (img_wr) begin
      case (img_addr)
        addr_space_pkg::VEC_HI_ADDR: next_vec = {img_wdata, vec[7:0]};
        addr_space_pkg::VEC_LO_ADDR: next_vec = {vec[15:8], img_wdata};
        addr_space_pkg::OPT_RESET_CFG: next_opt_reset_cfg = img_wdata;
        addr_space_pkg::OPT_CLOCK_CFG: next_opt_clock_cfg = img_wdata;
        default: next_vec = vec;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_rdata <= 8'h00;
      opt_reset_cfg <= addr_space_pkg::OPT_ERASED;
      opt_clock_cfg <= addr_space_pkg::OPT_ERASED;
      vec <= addr_space_pkg::VEC_ERASED;
    end else begin
      prog_rdata <= next_prog_rdata;
      opt_reset_cfg <= next_opt_reset_cfg;
      opt_clock_cfg <= next_opt_clock_cfg;
      vec <= next_vec;
    end
  end

  assign reset_entry = addr_space_pkg::RESET_ENTRY;
  assign irq_vector = vec;
  assign low_voltage_reset_en = opt_reset_cfg[addr_space_pkg::OPT_RESET_EN_BIT];
  assign internal_rc_sel = (opt_clock_cfg[1:0] == addr_space_pkg::OPT_CLOCK_RC);

  // register bus: working numbers map into page C, single page only
  assign eff_addr = reg_work ? {addr_space_pkg::WORK_PAGE, reg_addr[3:0]} : reg_addr;
  assign acc_ok = !lnk.busy;
  assign reg_busy = lnk.busy;
  assign ctrl_sel = acc_ok && (reg_rd || reg_wr) && (eff_addr > addr_space_pkg::WORK_TOP)
    && (eff_addr != addr_space_pkg::STACK_PTR_ADDR);
  assign push_slot = stack_pointer - 8'h01;

  always_comb begin
    rf_we = 1'b0;
    rf_waddr = eff_addr;
    rf_wdata = reg_wdata;
    next_stack_pointer = stack_pointer;
    if (lnk.push_en) begin
      rf_we = 1'b1;
      rf_waddr = push_slot;
      rf_wdata = lnk.push_data;
      next_stack_pointer = push_slot;
    end else if (lnk.pop_en) begin
      next_stack_pointer = stack_pointer + 8'h01;
    end else if (acc_ok && reg_wr) begin
      if (eff_addr == addr_space_pkg::STACK_PTR_ADDR) begin
        next_stack_pointer = reg_wdata;
      end else if (eff_addr <= addr_space_pkg::WORK_TOP) begin
        rf_we = 1'b1;
      end
    end
  end

  // the stack pointer keeps whatever it powers up with
  always_ff @(posedge clk) begin
    stack_pointer <= next_stack_pointer;
    if (rf_we) begin
      rf[rf_waddr] <= rf_wdata;
    end
  end

  assign pair_even = {pair_addr[7:1], 1'b0};

  always_comb begin
    next_reg_rdata = reg_rdata;
    next_pair_rdata = pair_rdata;
    if (acc_ok && reg_rd) begin
      if (eff_addr == addr_space_pkg::STACK_PTR_ADDR) begin
        next_reg_rdata = stack_pointer;
      end else if (eff_addr <= addr_space_pkg::WORK_TOP) begin
        next_reg_rdata = rf[eff_addr];
      end else begin
        next_reg_rdata = ctrl_rdata;
      end
    end
    if (pair_rd) begin
      next_pair_rdata = {rf[pair_even], rf[pair_even | 8'h01]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      pair_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_reg_rdata;
      pair_rdata <= next_pair_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_push_predec: assert property (lnk.push_en |=>
    stack_pointer == $past(stack_pointer) - 8'h01 && rf[stack_pointer] == $past(lnk.push_data))
    else $error("push did not store at decremented pointer");
  chk_pop_postinc: assert property (lnk.pop_en |=>
    stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("pop did not increment pointer");
  chk_fetch_data: assert property (prog_rd && !img_wr |=>
    prog_rdata == prog_mem[$past(prog_addr)])
    else $error("fetch returned wrong byte");
  chk_sp_readback: assert property (acc_ok && reg_rd && !reg_work &&
    reg_addr == addr_space_pkg::STACK_PTR_ADDR |=> reg_rdata == $past(stack_pointer))
    else $error("stack pointer read mismatch");
  chk_work_map: assert property (acc_ok && reg_wr && reg_work && !lnk.push_en |=>
    rf[{addr_space_pkg::WORK_PAGE, $past(reg_addr[3:0])}] == $past(reg_wdata))
    else $error("working register write misplaced");
  chk_pair_order: assert property (pair_rd && !rf_we |=>
    pair_rdata[15:8] == rf[{$past(pair_addr[7:1]), 1'b0}]
    && pair_rdata[7:0] == rf[{$past(pair_addr[7:1]), 1'b1}])
    else $error("register pair byte order wrong");
  chk_opt_decode: assert property (img_wr && img_addr == addr_space_pkg::OPT_RESET_CFG |=>
    low_voltage_reset_en == $past(img_wdata[7]))
    else $error("reset option decode wrong");
  chk_vec_load: assert property (img_wr && img_addr == addr_space_pkg::VEC_HI_ADDR |=>
    irq_vector[15:8] == $past(img_wdata))
    else $error("vector high byte not taken");
  chk_sp_wrap: assert property (lnk.push_en && stack_pointer == 8'h00 |=>
    stack_pointer == 8'hff)
    else $error("pointer did not wrap to ff");

  // register bus guards
  chk_ctrl_select: assert property (acc_ok && (reg_rd || reg_wr) && !reg_work &&
    reg_addr > addr_space_pkg::WORK_TOP && reg_addr != addr_space_pkg::STACK_PTR_ADDR
    |-> ctrl_sel && !rf_we)
    else $error("control access not passed outside");

  chk_work_no_ctrl: assert property (reg_work |-> !ctrl_sel)
    else $error("working access left the working area");

  chk_busy_refuse: assert property (lnk.busy && !lnk.push_en && !lnk.pop_en |=>
    stack_pointer == $past(stack_pointer))
    else $error("pointer changed while bus refused");

  chk_busy_no_sel: assert property (lnk.busy && !lnk.push_en |->
    !rf_we && !ctrl_sel)
    else $error("register access taken while busy");

  chk_gp_write: assert property (acc_ok && reg_wr && !reg_work &&
    reg_addr <= addr_space_pkg::GP_TOP |=> rf[$past(reg_addr)] == $past(reg_wdata))
    else $error("general purpose write lost");

  chk_sp_write: assert property (acc_ok && reg_wr && !reg_work &&
    reg_addr == addr_space_pkg::STACK_PTR_ADDR |=> stack_pointer == $past(reg_wdata))
    else $error("stack pointer write lost");

  chk_work_read: assert property (acc_ok && reg_rd && reg_work |=>
    reg_rdata == rf[{addr_space_pkg::WORK_PAGE, $past(reg_addr[3:0])}])
    else $error("working register read wrong");

  chk_ctrl_read: assert property (acc_ok && reg_rd && !reg_work &&
    reg_addr > addr_space_pkg::WORK_TOP && reg_addr != addr_space_pkg::STACK_PTR_ADDR
    |=> reg_rdata == $past(ctrl_rdata))
    else $error("control read not taken from outside");

  chk_read_hold: assert property (!(acc_ok && reg_rd) |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  chk_pair_hold: assert property (!pair_rd |=> $stable(pair_rdata))
    else $error("pair data changed without a read");

  // program memory guards
  chk_fetch_hold: assert property (!prog_rd |=> $stable(prog_rdata))
    else $error("fetch data changed without a fetch");

  chk_img_store: assert property (img_wr |=>
    prog_mem[$past(img_addr)] == $past(img_wdata))
    else $error("image byte not stored");

  chk_vec_lo_load: assert property (img_wr && img_addr == addr_space_pkg::VEC_LO_ADDR |=>
    irq_vector[7:0] == $past(img_wdata))
    else $error("vector low byte not taken");

  chk_clock_opt: assert property (img_wr && img_addr == addr_space_pkg::OPT_CLOCK_CFG |=>
    internal_rc_sel == ($past(img_wdata[1:0]) == addr_space_pkg::OPT_CLOCK_RC))
    else $error("clock option decode wrong");

  chk_opt_spare: assert property (img_wr && (img_addr == addr_space_pkg::OPT_SPARE0 ||
    img_addr == addr_space_pkg::OPT_SPARE1) |=> $stable({low_voltage_reset_en, internal_rc_sel})
    && $stable(irq_vector))
    else $error("spare option byte changed start-up state");

  // stack guards
  chk_done_pulse: assert property (stack_done |=> !stack_done)
    else $error("stack done held longer than one cycle");
endmodule

// ==== tb/cpu_model.sv ====
// partner model of the core issuing image, fetch, register and stack requests
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk,
  output logic img_wr,
  output logic [11:0] img_addr,
  output logic [7:0] img_wdata,
  output logic prog_rd,
  output logic [11:0] prog_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic reg_work,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic pair_rd,
  output logic [7:0] pair_addr,
  output addr_space_pkg::stack_cmd_e stack_cmd,
  output logic [15:0] program_counter_in,
  output logic [7:0] flags_in
);
  initial begin
    {img_wr, prog_rd, reg_rd, reg_wr, reg_work, pair_rd} = '0;
    {img_addr, img_wdata, prog_addr, reg_addr, reg_wdata, pair_addr} = '0;
    stack_cmd = addr_space_pkg::CMD_NONE;
    program_counter_in = '0;
    flags_in = '0;
  end
  // each request is held for one edge; released address and data lines show inverted values
  task automatic img(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    img_wr <= 1'b1;
    img_addr <= a;
    img_wdata <= d;
    @(posedge clk);
    img_wr <= 1'b0;
    img_addr <= ~a;
    img_wdata <= ~d;
  endtask
  task automatic fetch(input logic [11:0] a);
    @(posedge clk);
    prog_rd <= 1'b1;
    prog_addr <= a;
    @(posedge clk);
    prog_rd <= 1'b0;
    prog_addr <= ~a;
  endtask
  task automatic reg_acc(input logic w, input logic k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_work <= k;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    {reg_wr, reg_rd, reg_work} <= 3'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic pair(input logic [7:0] a);
    @(posedge clk);
    pair_rd <= 1'b1;
    pair_addr <= a;
    @(posedge clk);
    pair_rd <= 1'b0;
    pair_addr <= ~a;
  endtask
  task automatic stack(input addr_space_pkg::stack_cmd_e c, input logic [15:0] pc,
                       input logic [7:0] fl);
    @(posedge clk);
    stack_cmd <= c;
    program_counter_in <= pc;
    flags_in <= fl;
    @(posedge clk);
    stack_cmd <= addr_space_pkg::CMD_NONE;
    program_counter_in <= ~pc;
    flags_in <= ~fl;
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the address space and stack block
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst_n;
  logic [7:0] ctrl_rdata;
  logic img_wr, prog_rd, reg_rd, reg_wr, reg_work, pair_rd;
  logic [11:0] img_addr, prog_addr;
  logic [7:0] img_wdata, reg_addr, reg_wdata, pair_addr, flags_in, flags_out, stack_pointer;
  logic [7:0] prog_rdata, reg_rdata;
  logic [15:0] program_counter_in, program_counter_out, pair_rdata, reset_entry, irq_vector;
  logic low_voltage_reset_en, internal_rc_sel, reg_busy, ctrl_sel, stack_busy, stack_done;
  addr_space_pkg::stack_cmd_e stack_cmd;
  int error_cnt = 0;
  int cmp_count = 0;
  int ctrl_hits = 0;
  int m_reg[256];
  int m_prog[4096];
  int m_sp;

  addr_space_stack #(.PROG_DEPTH(4096)) u_addr_space_stack (
    .clk, .rst_n, .img_wr, .img_addr, .img_wdata, .prog_rd, .prog_addr, .prog_rdata,
    .reset_entry, .irq_vector, .low_voltage_reset_en, .internal_rc_sel, .reg_rd, .reg_wr,
    .reg_work, .reg_addr, .reg_wdata, .reg_rdata, .reg_busy, .ctrl_sel, .ctrl_rdata,
    .pair_rd, .pair_addr, .pair_rdata, .stack_cmd, .program_counter_in, .flags_in,
    .stack_busy, .stack_done, .program_counter_out, .flags_out, .stack_pointer);

  cpu_model u_cpu_model (
    .clk, .img_wr, .img_addr, .img_wdata, .prog_rd, .prog_addr, .reg_rd, .reg_wr, .reg_work,
    .reg_addr, .reg_wdata, .pair_rd, .pair_addr, .stack_cmd, .program_counter_in, .flags_in);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ctrl_sel === 1'b1) ctrl_hits++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic void m_push(input int b);
    m_sp = (m_sp + 255) % 256;
    m_reg[m_sp] = b;
  endfunction

  function automatic int m_pop();
    m_pop = m_reg[m_sp];
    m_sp = (m_sp + 1) % 256;
  endfunction

  task automatic do_stack(input addr_space_pkg::stack_cmd_e c, input int lat,
                          input logic [15:0] pc, input logic [7:0] fl);
    int n;
    int hi;
    n = 1;
    u_cpu_model.stack(c, pc, fl);
    do begin
      @(posedge clk);
      #1;
      n++;
      chk(16'({stack_busy, reg_busy}), 16'h0003);
    end while (stack_done !== 1'b1 && n < 10);
    chk(16'(n), 16'(lat));
    if (c == addr_space_pkg::CMD_CALL || c == addr_space_pkg::CMD_INT) begin
      m_push(pc[7:0]);
      m_push(pc[15:8]);
      if (c == addr_space_pkg::CMD_INT) m_push(fl);
    end else begin
      if (c == addr_space_pkg::CMD_INT_RETURN) chk(flags_out, 16'(m_pop()));
      hi = m_pop();
      chk(program_counter_out, 16'((hi << 8) | m_pop()));
    end
    chk(stack_pointer, 16'(m_sp));
  endtask

  task automatic rd_chk(input int a);
    u_cpu_model.reg_acc(1'b0, 1'b0, 8'(a), 8'h00);
    #1;
    chk(reg_rdata, 16'(m_reg[a]));
  endtask

  initial begin
    #(20 * 20000);
    error_cnt++;
    end_of_test();
  end

  initial begin
    int a;
    int d;
    int q[$];
    logic [15:0] pc;
    rst_n = 1'b0;
    ctrl_rdata = 8'h00;
    void'($urandom(41));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(irq_vector, 16'hffff);
    chk(16'({low_voltage_reset_en, internal_rc_sel}), 16'h0003);
    chk(reset_entry, 16'h0100);
    u_cpu_model.img(12'h03c, 8'h00);
    u_cpu_model.img(12'h03d, 8'h00);
    u_cpu_model.img(12'h03e, 8'h7f);
    u_cpu_model.img(12'h03f, 8'h02);
    u_cpu_model.img(12'h000, 8'h12);
    u_cpu_model.img(12'h001, 8'h34);
    @(posedge clk);
    #1;
    chk(16'({low_voltage_reset_en, internal_rc_sel}), 16'h0000);
    chk(irq_vector, 16'h1234);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 4095 : (i == 1) ? 256 : $urandom_range(64, 4095);
      m_prog[a] = $urandom_range(0, 255);
      q.push_back(a);
      u_cpu_model.img(12'(a), 8'(m_prog[a]));
    end
    foreach (q[i]) begin
      u_cpu_model.fetch(12'(q[i]));
      #1;
      chk(prog_rdata, 16'(m_prog[q[i]]));
    end
    q.delete();
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 191 : $urandom_range(0, 190);
      m_reg[a] = $urandom_range(0, 255);
      q.push_back(a);
      u_cpu_model.reg_acc(1'b1, 1'b0, 8'(a), 8'(m_reg[a]));
    end
    foreach (q[i]) rd_chk(q[i]);
    for (int i = 0; i < 4; i++) begin
      a = $urandom_range(0, 15);
      m_reg[192 + a] = $urandom_range(0, 255);
      u_cpu_model.reg_acc(1'b1, 1'b1, 8'(a), 8'(m_reg[192 + a]));
      u_cpu_model.reg_acc(1'b0, 1'b1, 8'(a), 8'h00);
      #1;
      chk(reg_rdata, 16'(m_reg[192 + a]));
    end
    a = 2 * $urandom_range(0, 95);
    m_reg[a] = $urandom_range(0, 255);
    m_reg[a + 1] = $urandom_range(0, 255);
    u_cpu_model.reg_acc(1'b1, 1'b0, 8'(a), 8'(m_reg[a]));
    u_cpu_model.reg_acc(1'b1, 1'b0, 8'(a + 1), 8'(m_reg[a + 1]));
    u_cpu_model.pair(8'(a + 1));
    #1;
    chk(pair_rdata, 16'((m_reg[a] << 8) | m_reg[a + 1]));
    d = $urandom_range(0, 255);
    @(posedge clk);
    ctrl_rdata <= 8'(d);
    u_cpu_model.reg_acc(1'b0, 1'b0, 8'hd5, 8'h00);
    #1;
    chk(reg_rdata, 16'(d));
    u_cpu_model.reg_acc(1'b1, 1'b0, 8'hd5, 8'(d));
    #1;
    chk(16'(ctrl_hits), 16'h0002);
    m_sp = 192;
    u_cpu_model.reg_acc(1'b1, 1'b0, 8'hd9, 8'hc0);
    u_cpu_model.reg_acc(1'b0, 1'b0, 8'hd9, 8'h00);
    #1;
    chk(reg_rdata, 16'h00c0);
    pc = 16'($urandom);
    do_stack(addr_space_pkg::CMD_CALL, 3, pc, 8'h00);
    rd_chk(191);
    rd_chk(190);
    do_stack(addr_space_pkg::CMD_INT, 4, 16'($urandom), 8'($urandom));
    rd_chk(187);
    do_stack(addr_space_pkg::CMD_INT_RETURN, 4, 16'h0000, 8'h00);
    do_stack(addr_space_pkg::CMD_SUB_RETURN, 3, 16'h0000, 8'h00);
    m_sp = 0;
    u_cpu_model.reg_acc(1'b1, 1'b0, 8'hd9, 8'h00);
    do_stack(addr_space_pkg::CMD_CALL, 3, 16'($urandom), 8'h00);
    do_stack(addr_space_pkg::CMD_SUB_RETURN, 3, 16'h0000, 8'h00);
    end_of_test();
  end
endmodule
